// ---- hdl/boot_base_decode.sv ----
`timescale 1ns/1ps
`include "vector_place_cfg.svh"

module boot_base_decode (
	input  wire logic [1:0]  bootSizeFuses,
	output logic      [13:0] bootStart
);
	// base comes from the boot size fuses, held in the bus-writable boot config register
	assign bootStart = (bootSizeFuses == 2'h0) ? `BOOT_START_4K :
	                   (bootSizeFuses == 2'h1) ? `BOOT_START_2K :
	                   (bootSizeFuses == 2'h2) ? `BOOT_START_1K : `BOOT_START_512;
endmodule : boot_base_decode

// ---- hdl/change_window.sv ----
`timescale 1ns/1ps
`include "vector_place_cfg.svh"

module change_window (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic setEnable,
	input  wire logic selWrite,
	input  wire logic instrDone,
	output logic      enableOpen,
	output logic      blockIrq
);
	vector_place_pkg::change_state_t state_r;
	vector_place_pkg::change_state_t state_nxt;
	logic [2:0] count_r;
	logic [2:0] count_nxt;

	// ----------------------------------------
	// window sequencing
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		case (state_r)
			vector_place_pkg::WIN_IDLE: begin
				if (setEnable) begin
					state_nxt = vector_place_pkg::WIN_OPEN;
					count_nxt = 3'h1;
				end
			end
			vector_place_pkg::WIN_OPEN: begin
				if (selWrite) begin
					state_nxt = vector_place_pkg::WIN_HOLD;
				end else if (setEnable) begin
					count_nxt = 3'h1;
				end else if (count_r == `CHANGE_WINDOW_CYC) begin
					state_nxt = vector_place_pkg::WIN_IDLE;
				end else begin
					count_nxt = count_r + 3'h1;
				end
			end
			vector_place_pkg::WIN_HOLD: begin
				// keep blocked through the following instruction
				// a fresh change enable reopens, else bit0 and state disagree
				if (setEnable) begin
					state_nxt = vector_place_pkg::WIN_OPEN;
					count_nxt = 3'h1;
				end else if (instrDone) begin
					state_nxt = vector_place_pkg::WIN_IDLE;
				end
			end
			default: state_nxt = vector_place_pkg::WIN_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= vector_place_pkg::WIN_IDLE;
			count_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
		end
	end

	assign enableOpen = (state_r == vector_place_pkg::WIN_OPEN);
	assign blockIrq   = (state_r != vector_place_pkg::WIN_IDLE);
endmodule : change_window

// ---- hdl/vector_place.sv ----
`timescale 1ns/1ps
`include "vector_place_cfg.svh"

module vector_place (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] execPc,
	input  wire logic        instrDone,
	input  wire logic        globalIntEnable,
	output logic      [13:0] vectorBase,
	output logic      [13:0] resetAddr,
	output logic             irqAllowed
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	vector_place_pkg::apb_req_t req;
	vector_place_pkg::boot_cfg_t bootCfg_r;
	logic [7:0]  gic_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [13:0] vectorBase_r;
	logic [13:0] resetAddr_r;
	logic        irqAllowed_r;
	logic [13:0] bootStart;
	logic        enableOpen;
	logic        blockWin;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

	wire access    = psel & penable & ~pready_r;
	wire hitGic    = (req.addr == `ADDR_GEN_INT_CTRL);
	wire hitStat   = (req.addr == `ADDR_PLACE_STATUS);
	wire hitCfg    = (req.addr == `ADDR_BOOT_CONFIG);
	wire hitPc     = (req.addr == `ADDR_EXEC_PC);
	wire mapped    = hitGic | hitStat | hitCfg | hitPc;
	wire wrGic     = access & req.write & hitGic;
	wire wrCfg     = access & req.write & hitCfg;
	wire wrCe      = wrGic & req.wdata[`BIT_CHANGE_ENABLE];
	// a write with enable clear while the window is open is the select write
	wire wrSel     = wrGic & ~req.wdata[`BIT_CHANGE_ENABLE] & enableOpen;
	wire [7:0] gicWr = req.wdata[7:0] & `GIC_WRITE_MASK;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	boot_base_decode baseDec (
		.bootSizeFuses (bootCfg_r.bootSizeFuses),
		.bootStart     (bootStart)
	);

	change_window chgWin (
		.clk        (clk),
		.rstn       (rstn),
		.setEnable  (wrCe),
		.selWrite   (wrSel),
		.instrDone  (instrDone),
		.enableOpen (enableOpen),
		.blockIrq   (blockWin)
	);

	// ----------------------------------------
	// control register next value
	// ----------------------------------------
	logic [7:0] gic_nxt;
	always_comb begin
		gic_nxt = gic_r;
		if (wrGic) begin
			gic_nxt[7:5] = gicWr[7:5];
			if (wrSel) begin
				gic_nxt[`BIT_VECTOR_SELECT] = gicWr[`BIT_VECTOR_SELECT];
			end
		end
		gic_nxt[`BIT_CHANGE_ENABLE] = enableOpen & ~wrSel;
		if (wrCe) begin
			gic_nxt[`BIT_CHANGE_ENABLE] = 1'b1;
		end
		gic_nxt[4:2] = 3'h0;
	end

	// ----------------------------------------
	// placement and blocking
	// ----------------------------------------
	wire sel       = gic_r[`BIT_VECTOR_SELECT];
	wire inBoot    = (execPc >= bootStart);
	wire lockBlock = (sel & ~bootCfg_r.appLockB & ~inBoot)
	               | (~sel & ~bootCfg_r.bootLockB & inBoot);
	// base plus boot start gives relocated table, e.g. 3802..3828 at 4K
	wire [13:0] baseNxt  = sel ? (bootStart + `APP_VECTOR_BASE)
	                           : `APP_VECTOR_BASE;
	// fuse zero means programmed
	wire [13:0] resetNxt = bootCfg_r.bootResetFuse ? `APP_RESET_ADDR
	                                               : bootStart;
	// the global flag is only read, never written here
	wire allowNxt  = globalIntEnable & ~blockWin & ~wrCe & ~lockBlock;

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [31:0] rdMux = hitGic  ? {24'h000000, gic_r} :
	                    hitStat ? {16'h0000, 1'b0, blockWin, vectorBase_r} :
	                    hitCfg  ? {27'h0000000, bootCfg_r} :
	                    hitPc   ? {18'h00000, execPc} : 32'h00000000;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gic_r     <= `GIC_RESET;
			bootCfg_r <= `BOOT_CFG_RESET;
		end else begin
			gic_r <= gic_nxt;
			if (wrCfg) begin
				bootCfg_r <= req.wdata[4:0];
			end
		end
	end

	// single wait state: answer one cycle into the access phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= access;
			pslverr_r <= access & ~mapped;
			prdata_r  <= (access & ~req.write) ? rdMux : 32'h00000000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			vectorBase_r <= `APP_VECTOR_BASE;
			resetAddr_r  <= `APP_RESET_ADDR;
			irqAllowed_r <= 1'b0;
		end else begin
			vectorBase_r <= baseNxt;
			resetAddr_r  <= resetNxt;
			irqAllowed_r <= allowNxt;
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign vectorBase = vectorBase_r;
	assign resetAddr  = resetAddr_r;
	assign irqAllowed = irqAllowed_r;
endmodule : vector_place

// ---- hdl/vector_place_cfg.svh ----
`ifndef VECTOR_PLACE_CFG_SVH
`define VECTOR_PLACE_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_GEN_INT_CTRL  12'h000
`define ADDR_PLACE_STATUS  12'h004
`define ADDR_BOOT_CONFIG   12'h008
`define ADDR_EXEC_PC       12'h00c

// ----------------------------------------
// general_int_control fields
// ----------------------------------------
`define BIT_CHANGE_ENABLE  0
`define BIT_VECTOR_SELECT  1
`define GIC_RESET          8'h00
`define GIC_WRITE_MASK     8'he3

// ----------------------------------------
// boot config fields and reset
// ----------------------------------------
`define BIT_BOOT_RESET     0
`define POS_BOOT_SIZE      1
`define BIT_APP_LOCK       3
`define BIT_BOOT_LOCK      4
`define BOOT_CFG_RESET     5'h07

// ----------------------------------------
// timing and addresses
// ----------------------------------------
`define CHANGE_WINDOW_CYC  3'h4
`define APP_VECTOR_BASE    14'h0002
`define APP_RESET_ADDR     14'h0000
`define BOOT_START_4K      14'h3800
`define BOOT_START_2K      14'h3c00
`define BOOT_START_1K      14'h3e00
`define BOOT_START_512     14'h3f00

`endif

// ---- hdl/vector_place_pkg.sv ----
package vector_place_pkg;

	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic [31:0] wdata;
	} apb_req_t;

	typedef struct packed {
		logic        bootLockB;
		logic        appLockB;
		logic [1:0]  bootSizeFuses;
		logic        bootResetFuse;
	} boot_cfg_t;

	typedef enum logic [1:0] {
		WIN_IDLE,
		WIN_OPEN,
		WIN_HOLD
	} change_state_t;

endpackage : vector_place_pkg

// ---- test/core_model.sv ----
`timescale 1ns/1ps
module core_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hold,
	input  wire logic        flagIn,
	input  wire logic [13:0] pcTarget,
	output logic      [13:0] execPc,
	output logic             instrDone,
	output logic             globalIntEnable
);
	// flag set by the bench only: the change block must never touch it
	assign globalIntEnable = flagIn;
	// hold stalls completion, the slow answer
	always_ff @(posedge clk) begin
		execPc    <= pcTarget;
		instrDone <= rstn && !hold && !instrDone;
	end
endmodule : core_model

// ---- test/test_interrupt_vector_placement.sv ----
`timescale 1ns/1ps
module test_interrupt_vector_placement;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d, q; logic e; logic [13:0] ra;} row_t;
	logic clk, rstn, psel, penable, pready, pslverr, instrDone, gie, irqAllowed, hold, e, flag;
	logic [31:0] prdata, q;
	logic [13:0] execPc, pcTarget, vectorBase, resetAddr;
	vector_place_pkg::apb_req_t req;
	int errTotal, comparisons, cycles;
	row_t rows[11] = '{
		'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0, 14'h0000},
		'{1'b0, 12'h008, 32'h0, 32'h07, 1'b0, 14'h0000},
		'{1'b1, 12'h000, 32'hfc, 32'h0, 1'b0, 14'h0000},
		'{1'b0, 12'h000, 32'h0, 32'he0, 1'b0, 14'h0000},
		'{1'b0, 12'h004, 32'h0, 32'h02, 1'b0, 14'h0000},
		'{1'b1, 12'h008, 32'h18, 32'h0, 1'b0, 14'h3800},
		'{1'b1, 12'h008, 32'h1a, 32'h0, 1'b0, 14'h3c00},
		'{1'b1, 12'h008, 32'h1c, 32'h0, 1'b0, 14'h3e00},
		'{1'b1, 12'h008, 32'h1e, 32'h0, 1'b0, 14'h3f00},
		'{1'b1, 12'h008, 32'h19, 32'h0, 1'b0, 14'h0000},
		'{1'b0, 12'h010, 32'h0, 32'h0, 1'b1, 14'h0000}};
	vector_place i_vector_place (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .execPc(execPc), .instrDone(instrDone),
		.globalIntEnable(gie), .vectorBase(vectorBase), .resetAddr(resetAddr),
		.irqAllowed(irqAllowed));
	core_model i_core_model (.clk(clk), .rstn(rstn), .hold(hold), .flagIn(flag), .pcTarget(pcTarget),
		.execPc(execPc), .instrDone(instrDone), .globalIntEnable(gie));
	always #20 clk = ~clk;
	// --------------------------------
	// bus, compare and closing tasks
	// --------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		req <= '{a, w, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic lockChk(input logic [31:0] cfg, input logic [13:0] pc, input logic ok);
		apb(1'b1, 12'h008, cfg);
		pcTarget <= pc;
		repeat (4) @(posedge clk);
		chk({31'h0, irqAllowed}, {31'h0, ok});
	endtask : lockChk
	task automatic stopTest();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stopTest
	// hang guard, the whole run needs about 150 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errTotal++;
			stopTest();
		end
	end
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		req = '0;
		hold = 1'b0;
		flag = 1'b1;
		pcTarget = 14'h3900;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].q);
			chk({e, 17'h0, resetAddr}, {rows[i].e, 17'h0, rows[i].ra});
		end
		// relocation with completion stalled
		apb(1'b1, 12'h008, 32'h18);
		hold <= 1'b1;
		apb(1'b1, 12'h000, 32'h01);
		apb(1'b1, 12'h000, 32'h02);
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h02);
		repeat (6) @(posedge clk);
		chk({irqAllowed, 17'h0, vectorBase}, {1'b0, 17'h0, 14'h3802});
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		chk({31'h0, irqAllowed}, 32'h1);
		// window left to expire, then a late select write
		apb(1'b1, 12'h000, 32'h01);
		chk({31'h0, irqAllowed}, 32'h0);
		repeat (6) @(posedge clk);
		chk({31'h0, irqAllowed}, 32'h1);
		apb(1'b1, 12'h000, 32'h00);
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h02);
		lockChk(32'h10, 14'h0100, 1'b0);
		lockChk(32'h10, 14'h3900, 1'b1);
		apb(1'b1, 12'h000, 32'h01);
		apb(1'b1, 12'h000, 32'h00);
		lockChk(32'h08, 14'h3900, 1'b0);
		lockChk(32'h08, 14'h0100, 1'b1);
		// flag low holds interrupts off, then they return untouched
		flag <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, irqAllowed}, 32'h0);
		flag <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, irqAllowed}, 32'h1);
		// second reset in mid-run
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h004, 32'h0);
		chk(q, 32'h02);
		stopTest();
	end
endmodule : test_interrupt_vector_placement

// ---- test/vector_place_monitor.sv ----
`timescale 1ns/1ps
module vector_place_monitor (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        globalIntEnable,
	input  wire logic [13:0] vectorBase,
	input  wire logic [13:0] resetAddr,
	input  wire logic        irqAllowed
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire take = psel && penable && !pready;
	wire setCe = take && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'h1;
	chk_ready_late: assert property (take |=> pready)
		else $error("no answer one cycle after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside an answer");
	chk_spare_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[4:2] == 3'h0)
		else $error("spare control bits not zero");
	chk_change_block: assert property (setCe |=> !irqAllowed[*3])
		else $error("interrupts open during change window");
	chk_vector_legal: assert property (vectorBase inside {14'h0002, 14'h3802, 14'h3c02, 14'h3e02, 14'h3f02})
		else $error("vector base off the allowed set");
	chk_reset_legal: assert property (resetAddr inside {14'h0000, 14'h3800, 14'h3c00, 14'h3e00, 14'h3f00})
		else $error("reset address off the allowed set");
	chk_flag_needed: assert property (irqAllowed |-> $past(globalIntEnable))
		else $error("interrupts allowed with flag clear");
	cover property (setCe);
	cover property (vectorBase == 14'h3802);
	cover property ($fell(irqAllowed));
endmodule : vector_place_monitor

bind vector_place vector_place_monitor i_mon (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .globalIntEnable, .vectorBase, .resetAddr, .irqAllowed);
